/* File: verilog/fecmd_pkg.sv */
// Package: constants, types and register map of the flash erase/unsecure command block
package fecmd_pkg;
  // AXI4-Lite register byte offsets
  localparam logic [7:0] FECMD_OFF_INDEX  = 8'h00; // Command word index
  localparam logic [7:0] FECMD_OFF_WORD   = 8'h04; // Command object word at current index
  localparam logic [7:0] FECMD_OFF_STATUS = 8'h08; // Flash status register
  localparam logic [7:0] FECMD_OFF_SECCFG = 8'h0c; // Security config register
  localparam logic [7:0] FECMD_OFF_CTRL   = 8'h10; // Mode, protection and array result control
  // Status bit positions
  localparam int FECMD_ST_CCF   = 7;
  localparam int FECMD_ST_ACC   = 5;
  localparam int FECMD_ST_PVIOL = 4;
  localparam int FECMD_ST_VERR  = 1;
  localparam int FECMD_ST_UNC   = 0;
  // Security config fields
  localparam int FECMD_SC_KEY_LO = 6;
  localparam int FECMD_SC_KEY_HI = 7;
  localparam int FECMD_SC_SEC_LO = 0;
  localparam int FECMD_SC_SEC_HI = 1;
  localparam logic [1:0] FECMD_KEY_ENABLED = 2'b10;
  localparam logic [1:0] FECMD_SEC_OPEN    = 2'b10;
  localparam logic [1:0] FECMD_SEC_CLOSED  = 2'b00;
  // Control fields
  localparam int FECMD_CT_MODE_OK = 0; // Erase/unsecure allowed in mode
  localparam int FECMD_CT_PROT_P  = 1; // P-flash has protected region
  localparam int FECMD_CT_PROT_D  = 2; // D-flash has protected region
  localparam int FECMD_CT_SECPROT = 3; // Addressed sector protected
  localparam int FECMD_CT_VFAIL   = 4; // Array verify reports error
  localparam int FECMD_CT_VUNC    = 5; // Array verify reports uncorrectable error
  // Command codes and required final index
  localparam logic [7:0] FECMD_CODE_BLK = 8'h09;
  localparam logic [7:0] FECMD_CODE_SEC = 8'h0a;
  localparam logic [7:0] FECMD_CODE_UNS = 8'h0b;
  localparam logic [7:0] FECMD_CODE_KEY = 8'h0c;
  localparam logic [2:0] FECMD_IDX_ERASE = 3'b001;
  localparam logic [2:0] FECMD_IDX_UNS   = 3'b000;
  localparam logic [2:0] FECMD_IDX_KEY   = 3'b100;
  // Block address field [22:16] kept in word 0 low 7 bits
  localparam logic [6:0] FECMD_BLK_D     = 7'h10;  // D-flash block number
  localparam logic [6:0] FECMD_BLK_P_MIN = 7'h40;  // First valid P-flash block
  localparam logic [15:0] FECMD_KEY_BASE = 16'hff00; // Key 0 at 0x7F_FF00
  // Erase time stand-in, in cycles of ref_clk
  localparam logic [15:0] FECMD_ERASE_CYC = 16'h0040;
  localparam logic [1:0] FECMD_RESP_OK     = 2'b00;
  localparam logic [1:0] FECMD_RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic ccf;
    logic acc;
    logic pviol;
    logic verr;
    logic unc;
  } fecmd_stat_t;

  // Gray along launch -> check -> erase -> verify; verify -> done flips two bits
  typedef enum logic [2:0] {
    FECMD_IDLE   = 3'b000,
    FECMD_CHECK  = 3'b001,
    FECMD_ERASE  = 3'b011,
    FECMD_VERIFY = 3'b010,
    FECMD_KEYCMP = 3'b110,
    FECMD_DONE   = 3'b111
  } fecmd_state_t;
endpackage

/* File: verilog/fecmd_timer.sv */
// Down counter that times the array erase phase
`timescale 1ns/10ps
module fecmd_timer #(
  parameter int WIDTH = 16
) (
  // Clock and control
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  // Load and status
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] count,
  output logic                  busy
);
  logic [WIDTH-1:0] cnt_reg;

  // Load takes priority so a fresh erase always restarts the count
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_reg <= '0;
    end else if (clk_en) begin
      if (load) cnt_reg <= count;
      else if (cnt_reg != '0) cnt_reg <= cnt_reg - 1'b1;
    end
  end

  assign busy = (cnt_reg != '0);
endmodule

/* File: verilog/fecmd_core.sv */
// Flash erase, sector erase, unsecure and backdoor key command sequencer
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps
module fecmd_core
  import fecmd_pkg::*;
#(
  parameter logic [15:0] ERASE_CYC = fecmd_pkg::FECMD_ERASE_CYC
) (
  // Clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Security and status
  output logic             secure_open,
  output logic             command_complete_flag
);
  import fecmd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [2:0]   command_word_index_reg;
  logic [15:0]  command_object_word_reg [0:4];
  logic [15:0]  key_store_reg [0:3];
  fecmd_stat_t  stat_reg;
  logic [7:0]   security_config_register_reg;
  logic [5:0]   ctrl_reg;
  logic         key_locked_reg;
  fecmd_state_t state_reg;
  logic         aw_got_reg, w_got_reg;
  logic [7:0]   aw_addr_reg;
  logic [31:0]  w_data_reg;
  logic         erase_load;
  logic         erase_busy;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data are latched in either order
  wire wr_fire   = aw_got_reg && w_got_reg && !s_axi_bvalid;
  wire wr_low    = s_axi_wstrb[0];
  wire wr_index  = wr_fire && (aw_addr_reg == FECMD_OFF_INDEX) && wr_low;
  wire wr_word   = wr_fire && (aw_addr_reg == FECMD_OFF_WORD) && wr_low;
  wire wr_status = wr_fire && (aw_addr_reg == FECMD_OFF_STATUS) && wr_low;
  wire wr_seccfg = wr_fire && (aw_addr_reg == FECMD_OFF_SECCFG) && wr_low;
  wire wr_ctrl   = wr_fire && (aw_addr_reg == FECMD_OFF_CTRL) && wr_low;
  wire wr_mapped = (aw_addr_reg == FECMD_OFF_INDEX) || (aw_addr_reg == FECMD_OFF_WORD)
                || (aw_addr_reg == FECMD_OFF_STATUS) || (aw_addr_reg == FECMD_OFF_SECCFG)
                || (aw_addr_reg == FECMD_OFF_CTRL);
  // Writing 1 to the complete flag launches; a launch write is ignored while busy
  wire idle      = (state_reg == FECMD_IDLE);
  wire launch    = wr_status && w_data_reg[FECMD_ST_CCF] && idle;
  wire clr_acc   = wr_status && w_data_reg[FECMD_ST_ACC];
  wire clr_pv    = wr_status && w_data_reg[FECMD_ST_PVIOL];
  // Next handshake state, worked out once so that every ready is a plain flip-flop
  wire aw_take     = s_axi_awvalid && s_axi_awready;
  wire w_take      = s_axi_wvalid && s_axi_wready;
  wire b_done      = s_axi_bvalid && s_axi_bready;
  wire aw_got_next = wr_fire ? 1'b0 : (aw_take || aw_got_reg);
  wire w_got_next  = wr_fire ? 1'b0 : (w_take || w_got_reg);
  wire bvalid_next = wr_fire || (s_axi_bvalid && !b_done);

  // A pending response blocks new writes, so one write at most is in flight
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= FECMD_RESP_OK;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
    end else if (clk_en) begin
      aw_got_reg    <= aw_got_next;
      w_got_reg     <= w_got_next;
      s_axi_bvalid  <= bvalid_next;
      // Ready falls as soon as a channel is held or a response waits
      s_axi_awready <= !aw_got_next && !bvalid_next;
      s_axi_wready  <= !w_got_next && !bvalid_next;
      if (aw_take) aw_addr_reg <= s_axi_awaddr;
      if (w_take) w_data_reg <= s_axi_wdata;
      if (wr_fire) s_axi_bresp <= wr_mapped ? FECMD_RESP_OK : FECMD_RESP_SLVERR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel
  logic [31:0] rd_mux;
  always_comb begin
    case (s_axi_araddr)
      FECMD_OFF_INDEX:  rd_mux = {29'h0, command_word_index_reg};
      // Indexes past the last word read as zero instead of running off the array
      FECMD_OFF_WORD:   rd_mux = (command_word_index_reg <= FECMD_IDX_KEY) ?
                                 {16'h0, command_object_word_reg[command_word_index_reg]} :
                                 32'h0000_0000;
      FECMD_OFF_STATUS: rd_mux = {24'h0, stat_reg.ccf, 1'b0, stat_reg.acc, stat_reg.pviol,
                                  2'b00, stat_reg.verr, stat_reg.unc};
      FECMD_OFF_SECCFG: rd_mux = {24'h0, security_config_register_reg};
      FECMD_OFF_CTRL:   rd_mux = {25'h0, key_locked_reg, ctrl_reg};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end
  // Unused or unaligned addresses answer with a slave error
  wire rd_mapped = (s_axi_araddr <= FECMD_OFF_CTRL) && (s_axi_araddr[1:0] == 2'b00);
  wire ar_take     = s_axi_arvalid && s_axi_arready;
  wire rvalid_next = ar_take || (s_axi_rvalid && !s_axi_rready);

  // Read data is captured at the taking edge so it stands for as long as rvalid
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= FECMD_RESP_OK;
      s_axi_arready <= 1'b1;
    end else if (clk_en) begin
      s_axi_rvalid  <= rvalid_next;
      s_axi_arready <= !rvalid_next;
      if (ar_take) begin
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_mapped ? FECMD_RESP_OK : FECMD_RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Launch checks, decoded from the loaded command object
  wire [7:0]  cmd_code  = command_object_word_reg[0][15:8];
  wire [6:0]  cmd_blk   = command_object_word_reg[0][6:0];
  wire [15:0] cmd_addr  = command_object_word_reg[1];
  wire is_blk = (cmd_code == FECMD_CODE_BLK);
  wire is_sec = (cmd_code == FECMD_CODE_SEC);
  wire is_uns = (cmd_code == FECMD_CODE_UNS);
  wire is_key = (cmd_code == FECMD_CODE_KEY);
  wire blk_is_d  = (cmd_blk == FECMD_BLK_D);
  wire blk_is_p  = (cmd_blk >= FECMD_BLK_P_MIN);
  wire idx_bad   = (is_blk || is_sec) ? (command_word_index_reg != FECMD_IDX_ERASE) :
                   is_uns ? (command_word_index_reg != FECMD_IDX_UNS) :
                   (command_word_index_reg != FECMD_IDX_KEY);
  wire mode_bad  = (is_blk || is_sec || is_uns) && !ctrl_reg[FECMD_CT_MODE_OK];
  // Phrase alignment for program flash, word alignment for data flash
  wire blk_bad   = is_blk && (!(blk_is_p || blk_is_d) ||
                   (blk_is_p && cmd_addr[2:0] != 3'b000) ||
                   (blk_is_d && cmd_addr[0]));
  wire sec_bad   = is_sec && (!blk_is_p || cmd_addr[2:0] != 3'b000);
  wire prot_any  = ctrl_reg[FECMD_CT_PROT_P] || ctrl_reg[FECMD_CT_PROT_D];
  wire pv_hit    = (is_blk && (blk_is_p ? ctrl_reg[FECMD_CT_PROT_P]
                                        : ctrl_reg[FECMD_CT_PROT_D]))
                || (is_sec && ctrl_reg[FECMD_CT_SECPROT])
                || (is_uns && prot_any);
  wire key_off   = security_config_register_reg[FECMD_SC_KEY_HI:FECMD_SC_KEY_LO]
                   != FECMD_KEY_ENABLED;
  wire unknown   = !(is_blk || is_sec || is_uns || is_key);
  wire acc_fail  = idx_bad || mode_bad || blk_bad || sec_bad || unknown
                || (is_key && (key_off || key_locked_reg));
  // Key words 1..4 against the stored comparison key, word 0 at the base location
  logic [3:0] key_eq;
  genvar gk;
  generate
    for (gk = 0; gk < 4; gk++) begin : g_key
      assign key_eq[gk] = (command_object_word_reg[gk+1] == key_store_reg[gk]);
    end
  endgenerate
  wire key_match = &key_eq;

  // The timer loads only on a clean launch, so a refused command never touches the array
  assign erase_load = (state_reg == FECMD_CHECK) && !acc_fail && !pv_hit && !is_key;

  fecmd_timer #(.WIDTH(16)) u_timer (
    .ref_clk (ref_clk),
    .reset   (reset),
    .clk_en  (clk_en),
    .load    (erase_load),
    .count   (ERASE_CYC),
    .busy    (erase_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= FECMD_IDLE;
    end else if (clk_en) begin
      case (state_reg)
        FECMD_IDLE:   if (launch) state_reg <= FECMD_CHECK;
        // Failed checks go straight to done with no array activity
        FECMD_CHECK:  state_reg <= (acc_fail || pv_hit) ? FECMD_DONE :
                                   is_key ? FECMD_KEYCMP : FECMD_ERASE;
        FECMD_ERASE:  if (!erase_busy && !erase_load) state_reg <= FECMD_VERIFY;
        FECMD_VERIFY: state_reg <= FECMD_DONE;
        FECMD_KEYCMP: state_reg <= FECMD_DONE;
        FECMD_DONE:   state_reg <= FECMD_IDLE;
        default:      state_reg <= FECMD_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags, security and software-held registers
  // Unsecure opens security only after a clean verify; any failure leaves the field as it was
  wire unsec_ok = is_uns && !ctrl_reg[FECMD_CT_VFAIL] && !ctrl_reg[FECMD_CT_VUNC];
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stat_reg                     <= '{ccf: 1'b1, default: 1'b0};
      security_config_register_reg <= 8'h00;
      ctrl_reg                     <= 6'h00;
      command_word_index_reg       <= 3'b000;
      key_locked_reg               <= 1'b0;
      for (int i = 0; i < 5; i++) command_object_word_reg[i] <= 16'h0000;
      for (int i = 0; i < 4; i++) key_store_reg[i] <= 16'h0000;
    end else if (clk_en) begin
      if (wr_index) command_word_index_reg <= w_data_reg[2:0];
      if (wr_word && idle && command_word_index_reg <= FECMD_IDX_KEY)
        command_object_word_reg[command_word_index_reg] <= w_data_reg[15:0];
      if (wr_ctrl) ctrl_reg <= w_data_reg[5:0];
      // Key store write reuses seccfg upper half as the key word select
      if (wr_seccfg && idle) begin
        security_config_register_reg <= w_data_reg[7:0];
        if (w_data_reg[31]) key_store_reg[w_data_reg[25:24]] <= w_data_reg[23:8];
      end
      // Sticky error flags: hardware set wins over software clear
      if (clr_acc) stat_reg.acc <= 1'b0;
      if (clr_pv) stat_reg.pviol <= 1'b0;
      // Launch clears the verify flags left by the previous command
      if (launch) begin
        stat_reg.ccf  <= 1'b0;
        stat_reg.verr <= 1'b0;
        stat_reg.unc  <= 1'b0;
      end
      if (state_reg == FECMD_CHECK) begin
        if (acc_fail) stat_reg.acc <= 1'b1;
        else if (pv_hit) stat_reg.pviol <= 1'b1;
      end
      if (state_reg == FECMD_VERIFY) begin
        stat_reg.verr <= ctrl_reg[FECMD_CT_VFAIL] || ctrl_reg[FECMD_CT_VUNC];
        stat_reg.unc  <= ctrl_reg[FECMD_CT_VUNC];
        if (unsec_ok)
          security_config_register_reg[FECMD_SC_SEC_HI:FECMD_SC_SEC_LO] <= FECMD_SEC_OPEN;
      end
      // A failed key locks out every later key command until reset
      if (state_reg == FECMD_KEYCMP) begin
        if (key_match)
          security_config_register_reg[FECMD_SC_SEC_HI:FECMD_SC_SEC_LO] <= FECMD_SEC_OPEN;
        else begin
          stat_reg.acc   <= 1'b1;
          key_locked_reg <= 1'b1;
        end
      end
      if (state_reg == FECMD_DONE) stat_reg.ccf <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      secure_open           <= 1'b0;
      command_complete_flag <= 1'b1;
    end else if (clk_en) begin
      secure_open <= security_config_register_reg[FECMD_SC_SEC_HI:FECMD_SC_SEC_LO]
                     == FECMD_SEC_OPEN;
      command_complete_flag <= stat_reg.ccf;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_idx_err_check: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && state_reg == FECMD_CHECK && idx_bad) |=> stat_reg.acc)
    else $error("index mismatch did not raise access error");
  a_mode_err_check: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && state_reg == FECMD_CHECK && mode_bad) |=> stat_reg.acc)
    else $error("mode violation did not raise access error");
  a_fail_fast_done: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && state_reg == FECMD_CHECK && acc_fail) ##1 clk_en |=> stat_reg.ccf)
    else $error("failed launch did not complete at once");
  a_prot_no_erase: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && state_reg == FECMD_CHECK && pv_hit)
    |=> (state_reg == FECMD_DONE) && !erase_busy)
    else $error("protected target was erased");
  a_blk_addr_err: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && state_reg == FECMD_CHECK && blk_bad) |=> stat_reg.acc)
    else $error("bad block address not flagged");
  a_sec_addr_err: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && state_reg == FECMD_CHECK && sec_bad) |=> stat_reg.acc)
    else $error("bad sector address not flagged");
  a_key_off_err: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && state_reg == FECMD_CHECK && is_key && key_off) |=> state_reg == FECMD_DONE)
    else $error("disabled key command compared");
  a_key_lock_hold: assert property (@(posedge ref_clk) disable iff (reset)
    key_locked_reg |=> key_locked_reg)
    else $error("key lock released before reset");
  a_unsec_keep_sec: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && state_reg == FECMD_VERIFY && is_uns && ctrl_reg[FECMD_CT_VFAIL])
    |=> $stable(security_config_register_reg[FECMD_SC_SEC_HI:FECMD_SC_SEC_LO]))
    else $error("failed unsecure changed security");
  a_key_no_pviol: assert property (@(posedge ref_clk) disable iff (reset)
    (state_reg == FECMD_KEYCMP) |=> !$rose(stat_reg.pviol) && !$rose(stat_reg.verr))
    else $error("key command set protection or verify flag");
endmodule

/* File: bench/fecmd_core_test.sv */
// Self-checking bench of the flash erase, unsecure and backdoor key sequencer
`timescale 1ns/10ps
module fecmd_core_test;
  import fecmd_pkg::*;
  logic        ref_clk, reset, clk_en, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, secure_open, ccf;
  int          failures, comparisons, cyc;
  logic [33:0] exp_q[$];
  logic [15:0] k[4], cw[5], a;
  logic [6:0]  pb;

  // Short erase count keeps the run brief; expectations use the same value
  fecmd_core #(.ERASE_CYC(16'h0010)) i_fecmd_core (
    .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .secure_open(secure_open), .command_complete_flag(ccf)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock; watchdog sized well above the 1,500 or so cycles the tests need
  always #10 ref_clk = ~ref_clk;
  initial begin
    #500_000;
    failures++;
    conclude();
  end

  // Read and write answers are compared against the oldest noted expectation
  always @(posedge ref_clk) begin
    if (rvalid && rready) begin
      check({rresp, rdata}, exp_q.pop_front());
    end
    if (bvalid && bready) begin
      check({bresp, 32'h0}, exp_q.pop_front());
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    comparisons++;
    if (seen !== want) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic conclude();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Ready is sampled at the falling edge; it is stable up to the taking edge
  task automatic wr(input logic [7:0] ad, input logic [31:0] d,
                    input logic [1:0] r = FECMD_RESP_OK);
    bit ta, tw, da, dw;
    da = 0;
    dw = 0;
    exp_q.push_back({r, 32'h0});
    @(posedge ref_clk);
    awaddr  <= ad;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge ref_clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      @(posedge ref_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      da |= ta;
      dw |= tw;
    end while (!(da && dw));
    do @(negedge ref_clk); while (bvalid !== 1'b1);
    @(posedge ref_clk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] d,
                    input logic [1:0] r = FECMD_RESP_OK);
    exp_q.push_back({r, d});
    @(posedge ref_clk);
    araddr  <= ad;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(negedge ref_clk); while (arready !== 1'b1);
    @(posedge ref_clk);
    arvalid <= 1'b0;
    do @(negedge ref_clk); while (rvalid !== 1'b1);
    @(posedge ref_clk);
    rready <= 1'b0;
  endtask

  function automatic logic [31:0] st(input logic e, input logic p, input logic v, input logic u);
    return {24'h0, 2'b10, e, p, 2'b00, v, u};
  endfunction

  task automatic opn(input logic e);
    check({33'h0, secure_open}, {33'h0, e});
  endtask

  // Key words go in with the enable field; security field is written closed
  // Keys sit in their own store, so the launching code never runs from it
  task automatic setkeys(input logic [1:0] en);
    for (int i = 0; i < 4; i++) wr(FECMD_OFF_SECCFG, {6'h20, 2'(i), k[i], en, 6'h0});
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
  endtask

  // Loads words, sets final index, launches, waits for completion, checks status
  task automatic run(input logic [7:0] code, input logic [6:0] blk, input logic [15:0] ad,
                     input logic [2:0] fin, input logic [5:0] ctl, input logic [31:0] want,
                     input int frz = 0);
    int n;
    n = (code == FECMD_CODE_KEY) ? 5 : ((code == FECMD_CODE_UNS) ? 1 : 2);
    cw[0] = {code, 1'b0, blk};
    if (n == 2) cw[1] = ad;
    wr(FECMD_OFF_CTRL, {26'h0, ctl});
    for (int i = 0; i < n; i++) begin
      wr(FECMD_OFF_INDEX, i);
      wr(FECMD_OFF_WORD, {16'h0, cw[i]});
    end
    wr(FECMD_OFF_INDEX, {29'h0, fin});
    wr(FECMD_OFF_STATUS, 32'h80);
    // The flag copy lags the launch, so look once it has settled
    @(negedge ref_clk);
    check({33'h0, ccf}, 34'h0);
    // A low enable must hold the command where it stands
    if (frz > 0) begin
      @(posedge ref_clk);
      clk_en <= 1'b0;
      repeat (frz) @(posedge ref_clk);
      check({33'h0, ccf}, 34'h0);
      clk_en <= 1'b1;
    end
    cyc = 0;
    // No register write until the command has completed
    while (ccf !== 1'b1 && cyc < 500) begin
      @(posedge ref_clk);
      cyc++;
    end
    check({33'h0, cyc < 500}, 34'h1);
    if (want[5] | want[4]) check({33'h0, cyc < 8}, 34'h1);
    else if (code != FECMD_CODE_KEY) check({33'h0, cyc > 15}, 34'h1);
    rd(FECMD_OFF_STATUS, want);
    wr(FECMD_OFF_STATUS, 32'h30);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    ref_clk = 0; reset = 1; clk_en = 1; awvalid = 0; wvalid = 0; bready = 0;
    arvalid = 0; rready = 0; awaddr = 0; araddr = 0; wdata = 0;
    failures = 0; comparisons = 0;
    void'($urandom(57603));
    pb = 7'h40 | 7'($urandom() & 32'h3f);
    a = 16'($urandom()) & 16'hfff8;
    for (int i = 0; i < 4; i++) k[i] = 16'($urandom());
    do_reset();
    rd(FECMD_OFF_STATUS, st(0, 0, 0, 0));
    rd(8'h20, 32'h0, FECMD_RESP_SLVERR);
    wr(8'h20, 32'h0, FECMD_RESP_SLVERR);
    run(FECMD_CODE_BLK, pb, a, 3'b001, 6'h01, st(0, 0, 0, 0));
    run(FECMD_CODE_BLK, FECMD_BLK_D, a | 16'h2, 3'b001, 6'h01, st(0, 0, 0, 0), 40);
    run(FECMD_CODE_BLK, pb, a, 3'b010, 6'h01, st(1, 0, 0, 0));
    run(FECMD_CODE_BLK, pb, a, 3'b001, 6'h00, st(1, 0, 0, 0));
    run(FECMD_CODE_BLK, 7'h20, a, 3'b001, 6'h01, st(1, 0, 0, 0));
    run(FECMD_CODE_BLK, pb, a | 16'h2, 3'b001, 6'h01, st(1, 0, 0, 0));
    run(FECMD_CODE_BLK, FECMD_BLK_D, a | 16'h1, 3'b001, 6'h01, st(1, 0, 0, 0));
    run(FECMD_CODE_BLK, pb, a, 3'b001, 6'h03, st(0, 1, 0, 0));
    run(FECMD_CODE_BLK, FECMD_BLK_D, a, 3'b001, 6'h05, st(0, 1, 0, 0));
    run(FECMD_CODE_BLK, pb, a, 3'b001, 6'h05, st(0, 0, 0, 0));
    run(8'h0d, pb, a, 3'b001, 6'h01, st(1, 0, 0, 0));
    run(FECMD_CODE_BLK, pb, a, 3'b001, 6'h31, st(0, 0, 1, 1));
    run(FECMD_CODE_SEC, pb, a | 16'h4, 3'b001, 6'h01, st(1, 0, 0, 0));
    run(FECMD_CODE_SEC, 7'h20, a, 3'b001, 6'h01, st(1, 0, 0, 0));
    run(FECMD_CODE_SEC, pb, a, 3'b001, 6'h09, st(0, 1, 0, 0));
    run(FECMD_CODE_SEC, pb, a, 3'b001, 6'h11, st(0, 0, 1, 0));
    run(FECMD_CODE_SEC, pb, a | 16'h3f8, 3'b001, 6'h01, st(0, 0, 0, 0));
    run(FECMD_CODE_UNS, 7'h0, a, 3'b001, 6'h01, st(1, 0, 0, 0));
    run(FECMD_CODE_UNS, 7'h0, a, 3'b000, 6'h00, st(1, 0, 0, 0));
    run(FECMD_CODE_UNS, 7'h0, a, 3'b000, 6'h05, st(0, 1, 0, 0));
    run(FECMD_CODE_UNS, 7'h0, a, 3'b000, 6'h11, st(0, 0, 1, 0));
    opn(1'b0);
    run(FECMD_CODE_UNS, 7'h0, a, 3'b000, 6'h01, st(0, 0, 0, 0));
    opn(1'b1);
    for (int i = 0; i < 4; i++) cw[i + 1] = k[i];
    setkeys(2'b00);
    run(FECMD_CODE_KEY, 7'h0, a, 3'b100, 6'h3f, st(1, 0, 0, 0));
    opn(1'b0);
    setkeys(FECMD_KEY_ENABLED);
    run(FECMD_CODE_KEY, 7'h0, a, 3'b011, 6'h3f, st(1, 0, 0, 0));
    run(FECMD_CODE_KEY, 7'h0, a, 3'b100, 6'h3f, st(0, 0, 0, 0));
    opn(1'b1);
    setkeys(FECMD_KEY_ENABLED);
    cw[2] = ~k[1];
    run(FECMD_CODE_KEY, 7'h0, a, 3'b100, 6'h3f, st(1, 0, 0, 0));
    cw[2] = k[1];
    run(FECMD_CODE_KEY, 7'h0, a, 3'b100, 6'h3f, st(1, 0, 0, 0));
    opn(1'b0);
    do_reset();
    setkeys(FECMD_KEY_ENABLED);
    run(FECMD_CODE_KEY, 7'h0, a, 3'b100, 6'h01, st(0, 0, 0, 0));
    opn(1'b1);
    conclude();
  end
endmodule
